// ### logic/vpo_defines.vh
// Constants of the video pixel output port: register map, fields, reset values, codes
// Behaviour
// - 16-bit YCbCr and RGB words leave after a clock edge with qualifier asserted.
// - RGB modes output linear or gamma-corrected colour as configured.
// - Inactive, syncs, qualifier, ancillary and field flags change after a clock edge.
// - Inactive without ancillary forces Y 16, Cb/Cr 128, or RGB all zero.
// - Qualifier behaviour set by bits 4 and 5 of genlock control.
// - Gated select needs active-low polarity; then low in active, strobed in blanking.
// - With 4:2:2 the two chroma components alternate on successive outputs.
// - Every-pixel select asserts the qualifier for each valid pixel everywhere.
// - Embedded-sync mode puts one byte on the upper eight lines every clock.
// - EAV and SAV placed by the programmed horizontal blanking on every line; V follows vertical blanking.
// - Embedded-sync blanking bytes are 16 and 128 unless ancillary data is inserted.
// - During a preamble the qualifier is deasserted and inactive flag asserted.
// - Timing reference is FF, 00, 00, then status word with a leading one.
// - F is 0 in field 1, V is 1 in vertical blanking, H is 1 in EAV.
// - Inactive flag set at start count, cleared at end count; inactive lines whole.
// - Pixel data leaves on sixteen lines whose meaning follows the format.
`ifndef VPO_DEFINES_VH
`define VPO_DEFINES_VH
// Register indices; byte address is four times the index
`define VPO_IDX_GENLOCK  8'h04
`define VPO_IDX_FORMAT   8'h05
`define VPO_IDX_STATUS   8'h06
`define VPO_IDX_HTOTAL   8'h07
`define VPO_IDX_VTOTAL   8'h08
`define VPO_IDX_HSTART   8'h30
`define VPO_IDX_HEND     8'h32
`define VPO_IDX_VSTART   8'h33
`define VPO_IDX_VEND     8'h35
// Field positions
`define VPO_GL_GATED     4
`define VPO_GL_EVERY     5
`define VPO_FMT_GAMMA    2
`define VPO_FMT_QLOW     3
// Output formats
`define VPO_MODE_YC16    2'h0
`define VPO_MODE_RGB15   2'h1
`define VPO_MODE_RGB16   2'h2
`define VPO_MODE_EMB8    2'h3
// Reset values
`define VPO_RST_GENLOCK  8'h00
`define VPO_RST_FORMAT   4'h0
`define VPO_RST_HTOTAL   10'h359
`define VPO_RST_HSTART   10'h34a
`define VPO_RST_HEND     10'h07a
`define VPO_RST_VSTART   10'h103
`define VPO_RST_VEND     10'h013
`define VPO_RST_VTOTAL   10'h106
// Blanking levels, preamble bytes and sync lengths
`define VPO_LUMA_BLK     8'h10
`define VPO_CHROMA_BLK   8'h80
`define VPO_PRE_ONES     8'hff
`define VPO_PRE_ZERO     8'h00
`define VPO_HSYNC_LEN    10'h040
`define VPO_VSYNC_LINES  10'h003
`endif

// ### logic/vpo_pixel_port.v
// Video pixel output formatter with APB register file and embedded timing references
`timescale 1ns/10ps
`default_nettype none
`include "vpo_defines.vh"
module vpo_pixel_port #(
  parameter CNT_W = 10
) (
  input  wire        clk,          // Output sample clock
  input  wire        reset,        // Asynchronous, active high
  input  wire        psel,         // APB select
  input  wire        penable,      // APB access phase
  input  wire        pwrite,       // APB direction
  input  wire [11:0] paddr,        // APB byte address
  input  wire [31:0] pwdata,       // APB write data
  output reg  [31:0] prdata,       // APB read data
  output wire        pready,       // APB ready, no wait states
  output wire        pslverr,      // APB error on unmapped address
  input  wire        pixStrobe,    // New pixel from rate converter
  input  wire [7:0]  yIn,          // Luma sample
  input  wire [7:0]  cbIn,         // Blue chroma sample
  input  wire [7:0]  crIn,         // Red chroma sample
  input  wire [7:0]  rIn,          // Linear red
  input  wire [7:0]  gIn,          // Linear green
  input  wire [7:0]  bIn,          // Linear blue
  input  wire        ancActive,    // Ancillary packet byte present
  input  wire [7:0]  ancByte,      // Ancillary packet byte
  output reg  [15:0] pixOut,       // Pixel lines P0 to P15
  output reg         inactiveFlag, // Blanking region flag
  output reg         hsyncOut,     // Line sync
  output reg         vsyncOut,     // Frame sync
  output reg         pixelQualifier, // Data qualifier, polarity per format reg
  output reg         ancillaryWindowFlag, // Ancillary data window
  output reg         fieldOut      // 0 field 1, 1 field 2
);

  // Register file
  reg  [7:0]       genlock_reg;
  reg  [3:0]       format_reg;
  reg  [CNT_W-1:0] hTotal_reg;
  reg  [CNT_W-1:0] vTotal_reg;
  reg  [CNT_W-1:0] hStart_reg;
  reg  [CNT_W-1:0] hEnd_reg;
  reg  [CNT_W-1:0] vStart_reg;
  reg  [CNT_W-1:0] vEnd_reg;

  // Timing state
  reg  [CNT_W-1:0] hCount_reg;
  reg  [CNT_W-1:0] vCount_reg;
  reg              field_reg;
  reg              hBlank_reg;
  reg              chromaSel_reg;
  reg  [1:0]       trsPhase_reg;
  reg              trsActive_reg;
  reg              trsIsEav_reg;

  wire [7:0]       regIdx;
  wire             wrEn;
  wire             mapped;
  wire [1:0]       mode;
  wire             embMode;
  wire             step;
  wire             hWrap;
  wire             vWrap;
  wire             lineInactive;
  wire             inactiveNow;
  wire             trsStartEav;
  wire             trsStartSav;
  wire             inTrs;
  wire             trsH;
  wire [7:0]       statusWord;
  wire [7:0]       chromaNow;
  wire [7:0]       rOut;
  wire [7:0]       gOut;
  wire [7:0]       bOut;
  reg  [7:0]       embByte;
  reg  [15:0]      pixNext;
  reg              qualNext;

  assign regIdx  = paddr[9:2];
  assign wrEn    = psel & penable & pwrite;
  // No wait states: every register reads through a fixed mux
  assign pready  = 1'b1;
  // Unaligned or out-of-window words are refused so software faults show as slave errors
  assign mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                   (regIdx == `VPO_IDX_GENLOCK || regIdx == `VPO_IDX_FORMAT ||
                    regIdx == `VPO_IDX_STATUS  || regIdx == `VPO_IDX_HTOTAL ||
                    regIdx == `VPO_IDX_VTOTAL  || regIdx == `VPO_IDX_HSTART ||
                    regIdx == `VPO_IDX_HEND    || regIdx == `VPO_IDX_VSTART ||
                    regIdx == `VPO_IDX_VEND);
  assign pslverr = psel & penable & ~mapped;

  // APB writes; the status word is read only
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      genlock_reg <= `VPO_RST_GENLOCK;
      format_reg  <= `VPO_RST_FORMAT;
      hTotal_reg  <= `VPO_RST_HTOTAL;
      vTotal_reg  <= `VPO_RST_VTOTAL;
      hStart_reg  <= `VPO_RST_HSTART;
      hEnd_reg    <= `VPO_RST_HEND;
      vStart_reg  <= `VPO_RST_VSTART;
      vEnd_reg    <= `VPO_RST_VEND;
    end else if (wrEn && mapped) begin
      case (regIdx)
        `VPO_IDX_GENLOCK: genlock_reg <= pwdata[7:0];
        `VPO_IDX_FORMAT:  format_reg  <= pwdata[3:0];
        `VPO_IDX_HTOTAL:  hTotal_reg  <= pwdata[CNT_W-1:0];
        `VPO_IDX_VTOTAL:  vTotal_reg  <= pwdata[CNT_W-1:0];
        `VPO_IDX_HSTART:  hStart_reg  <= pwdata[CNT_W-1:0];
        `VPO_IDX_HEND:    hEnd_reg    <= pwdata[CNT_W-1:0];
        `VPO_IDX_VSTART:  vStart_reg  <= pwdata[CNT_W-1:0];
        `VPO_IDX_VEND:    vEnd_reg    <= pwdata[CNT_W-1:0];
        default:          genlock_reg <= genlock_reg;
      endcase
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    prdata = 32'h00000000;
    case (regIdx)
      `VPO_IDX_GENLOCK: prdata[7:0] = genlock_reg;
      `VPO_IDX_FORMAT:  prdata[3:0] = format_reg;
      // Flags in bits 23 to 21, line count in 19:10, pixel count in 9:0
      `VPO_IDX_STATUS:  prdata = {8'h00, trsActive_reg, hBlank_reg, field_reg,
                                  1'b0, vCount_reg[9:0], hCount_reg[9:0]};
      `VPO_IDX_HTOTAL:  prdata[CNT_W-1:0] = hTotal_reg;
      `VPO_IDX_VTOTAL:  prdata[CNT_W-1:0] = vTotal_reg;
      `VPO_IDX_HSTART:  prdata[CNT_W-1:0] = hStart_reg;
      `VPO_IDX_HEND:    prdata[CNT_W-1:0] = hEnd_reg;
      `VPO_IDX_VSTART:  prdata[CNT_W-1:0] = vStart_reg;
      `VPO_IDX_VEND:    prdata[CNT_W-1:0] = vEnd_reg;
      default:          prdata = 32'h00000000;
    endcase
    if (!mapped) begin
      prdata = 32'h00000000;
    end
  end

  // Embedded-sync mode advances one byte every clock, others follow the strobe
  assign mode    = format_reg[1:0];
  assign embMode = (mode == `VPO_MODE_EMB8);
  assign step    = embMode | pixStrobe;
  assign hWrap   = (hCount_reg == hTotal_reg);
  assign vWrap   = (vCount_reg == vTotal_reg);

  // Whole inactive lines, wrapping across the field boundary
  assign lineInactive = (vCount_reg >= vStart_reg) || (vCount_reg < vEnd_reg);
  assign inactiveNow  = hBlank_reg | lineInactive;

  // Pixel and line counters; the field flips when the last line wraps
  // Line count and field move only at a line wrap, so a status read sees one line
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hCount_reg <= {CNT_W{1'b0}};
      vCount_reg <= {CNT_W{1'b0}};
      field_reg  <= 1'b0;
    end else if (step) begin
      if (hWrap) begin
        hCount_reg <= {CNT_W{1'b0}};
        if (vWrap) begin
          vCount_reg <= {CNT_W{1'b0}};
          field_reg  <= ~field_reg;
        end else begin
          vCount_reg <= vCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        hCount_reg <= hCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Horizontal blanking window: set at start count, released at end count
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hBlank_reg <= 1'b1;
    end else if (step) begin
      if (hCount_reg == hStart_reg) begin
        hBlank_reg <= 1'b1;
      end else if (hCount_reg == hEnd_reg) begin
        hBlank_reg <= 1'b0;
      end
    end
  end

  // Timing references: EAV opens blanking, SAV takes the four bytes before it ends
  // Limitation: hEnd below four would wrap the SAV compare, so keep it at four or more
  assign trsStartEav = embMode && (hCount_reg == hStart_reg);
  assign trsStartSav = embMode &&
                       (hCount_reg == hEnd_reg - {{(CNT_W-3){1'b0}}, 3'h4});
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      trsActive_reg <= 1'b0;
      trsPhase_reg  <= 2'h0;
      trsIsEav_reg  <= 1'b0;
    end else if (!embMode) begin
      trsActive_reg <= 1'b0;
      trsPhase_reg  <= 2'h0;
    end else if (trsStartEav || trsStartSav) begin
      trsActive_reg <= 1'b1;
      trsPhase_reg  <= 2'h1;
      trsIsEav_reg  <= trsStartEav;
    end else if (trsActive_reg) begin
      trsPhase_reg  <= trsPhase_reg + 2'h1;
      trsActive_reg <= (trsPhase_reg != 2'h3);
    end
  end
  assign inTrs = trsStartEav | trsStartSav | trsActive_reg;
  assign trsH  = trsActive_reg ? trsIsEav_reg : trsStartEav;

  // Status word: leading one, F V H, then protection bits
  assign statusWord = {1'b1, field_reg, lineInactive, trsH,
                       lineInactive ^ trsH, field_reg ^ trsH,
                       field_reg ^ lineInactive,
                       field_reg ^ lineInactive ^ trsH};

  // Chroma alternates per output, restarting on Cb at each active line
  // Restarting per line keeps Cb and Cr paired even when the active width is odd
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      chromaSel_reg <= 1'b0;
    end else if (step) begin
      if (inactiveNow) begin
        chromaSel_reg <= 1'b0;
      end else begin
        chromaSel_reg <= ~chromaSel_reg;
      end
    end
  end
  assign chromaNow = chromaSel_reg ? crIn : cbIn;

  // Cheap gamma lift: x + x(255-x)/512 stays within eight bits
  // Trade-off: a curve of one multiply replaces a lookup table per colour
  function [7:0] gammaLift;
    input [7:0] x;
    reg   [15:0] prod;
    reg   [8:0]  sum;
    begin
      prod      = x * (8'hff - x);
      sum       = {1'b0, x} + {2'h0, prod[15:9]};
      gammaLift = sum[7:0];
    end
  endfunction

  assign rOut = format_reg[`VPO_FMT_GAMMA] ? gammaLift(rIn) : rIn;
  assign gOut = format_reg[`VPO_FMT_GAMMA] ? gammaLift(gIn) : gIn;
  assign bOut = format_reg[`VPO_FMT_GAMMA] ? gammaLift(bIn) : bIn;

  // Embedded-sync byte: preamble, status, ancillary, blanking or Cb Y Cr Y
  always @* begin
    embByte = yIn;
    if (inTrs) begin
      if (!trsActive_reg) begin
        embByte = `VPO_PRE_ONES;
      end else if (trsPhase_reg == 2'h3) begin
        embByte = statusWord;
      end else begin
        embByte = `VPO_PRE_ZERO;
      end
    end else if (ancActive) begin
      embByte = ancByte;
    end else if (inactiveNow) begin
      embByte = hCount_reg[0] ? `VPO_LUMA_BLK : `VPO_CHROMA_BLK;
    end else if (!hCount_reg[0]) begin
      embByte = hCount_reg[1] ? crIn : cbIn;
    end
  end

  // Word per format, forced to blanking levels outside ancillary windows
  always @* begin
    pixNext = pixOut;
    case (mode)
      `VPO_MODE_YC16: begin
        if (inactiveNow && !ancActive) begin
          pixNext = {`VPO_LUMA_BLK, `VPO_CHROMA_BLK};
        end else begin
          pixNext = {yIn, chromaNow};
        end
      end
      `VPO_MODE_RGB15: begin
        if (inactiveNow && !ancActive) begin
          pixNext = 16'h0000;
        end else begin
          pixNext = {1'b0, rOut[7:3], gOut[7:3], bOut[7:3]};
        end
      end
      `VPO_MODE_RGB16: begin
        if (inactiveNow && !ancActive) begin
          pixNext = 16'h0000;
        end else begin
          pixNext = {rOut[7:3], gOut[7:2], bOut[7:3]};
        end
      end
      `VPO_MODE_EMB8: begin
        pixNext = {embByte, 8'h00};
      end
      default: begin
        pixNext = 16'h0000;
      end
    endcase
  end

  // Qualifier before polarity; note its spacing follows the strobe, not a fixed duty
  // Gated mode relies on software setting active-low polarity; nothing here enforces it
  always @* begin
    qualNext = 1'b0;
    if (inTrs) begin
      qualNext = 1'b0;
    end else if (genlock_reg[`VPO_GL_EVERY]) begin
      qualNext = step;
    end else if (genlock_reg[`VPO_GL_GATED]) begin
      qualNext = inactiveNow ? step : 1'b1;
    end else begin
      qualNext = step & ~inactiveNow;
    end
  end

  // All port flags and data are registered, so they move just after the edge
  // Data holds between steps so a receiver may latch it on any qualified edge
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pixOut              <= {`VPO_LUMA_BLK, `VPO_CHROMA_BLK};
      inactiveFlag        <= 1'b1;
      hsyncOut            <= 1'b0;
      vsyncOut            <= 1'b0;
      pixelQualifier      <= 1'b0;
      ancillaryWindowFlag <= 1'b0;
      fieldOut            <= 1'b0;
    end else begin
      if (step) begin
        pixOut <= pixNext;
      end
      inactiveFlag        <= inactiveNow | inTrs;
      hsyncOut            <= (hCount_reg < `VPO_HSYNC_LEN);
      vsyncOut            <= (vCount_reg < `VPO_VSYNC_LINES);
      pixelQualifier      <= qualNext ^ format_reg[`VPO_FMT_QLOW];
      ancillaryWindowFlag <= ancActive;
      fieldOut            <= field_reg;
    end
  end

endmodule // vpo_pixel_port
`default_nettype wire

// ### tb/vpo_pixel_port_properties.sv
// Checker for the pixel output port: bus answer, qualifier modes and timing references
`timescale 1ns/10ps
`default_nettype none
module vpo_pixel_port_props (
  input wire logic        clk,                 // Sample clock
  input wire logic        reset,               // Async reset
  input wire logic        psel,                // APB select
  input wire logic        penable,             // APB access
  input wire logic        pwrite,              // APB direction
  input wire logic [11:0] paddr,               // APB address
  input wire logic [31:0] pwdata,              // APB write data
  input wire logic        pready,              // APB ready
  input wire logic        pslverr,             // APB error
  input wire logic        pixStrobe,           // Pixel step
  input wire logic        ancActive,           // Ancillary present
  input wire logic [15:0] pixOut,              // Pixel lines
  input wire logic        inactiveFlag,        // Blanking flag
  input wire logic        pixelQualifier,      // Qualifier
  input wire logic        ancillaryWindowFlag  // Ancillary window
);
  logic [7:0] glReg;
  logic [3:0] fmtReg;
  logic       trsStart;
  logic       embOld;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of genlock and format, so relations follow the mode in force
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      glReg <= 8'h00;
      fmtReg <= 4'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h010) glReg <= pwdata[7:0];
      if (paddr == 12'h014) fmtReg <= pwdata[3:0];
    end
  end
  // Embedded mode in force for a full cycle, so a stale word from the last mode is ignored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) embOld <= 1'b0;
    else embOld <= fmtReg[1:0] == 2'h3;
  end
  // Preamble start; active bytes never count since the flag is low there
  assign trsStart = embOld && fmtReg[1:0] == 2'h3 && inactiveFlag && pixOut[15:8] == 8'hff;
  a_emb_low: assert property (embOld && fmtReg[1:0] == 2'h3 |-> pixOut[7:0] == 8'h00)
    else $error("lower lines not zero in embedded-sync mode");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_anc_delay: assert property (ancillaryWindowFlag == $past(ancActive))
    else $error("ancillary window flag not one cycle behind");
  a_trs_order: assert property (trsStart |=> pixOut[15:8] == 8'h00 ##1 pixOut[15:8] == 8'h00 ##1 pixOut[15])
    else $error("timing reference bytes out of order");
  a_trs_parity: assert property (trsStart |-> ##3 (pixOut[11] == (pixOut[13] ^ pixOut[12])
    && pixOut[10] == (pixOut[14] ^ pixOut[12]) && pixOut[9] == (pixOut[14] ^ pixOut[13])
    && pixOut[8] == (^pixOut[14:12]))) else $error("status word protection bits wrong");
  a_trs_quiet: assert property (trsStart |-> (inactiveFlag && pixelQualifier == fmtReg[3]) [*4])
    else $error("qualifier active during preamble");
  a_every_qual: assert property (glReg[5] && $past(glReg[5]) && fmtReg[1:0] != 2'h3 && !fmtReg[3]
    |-> pixelQualifier == $past(pixStrobe)) else $error("qualifier does not follow each pixel");
  a_gated_act: assert property (fmtReg == 4'h8 && $past(fmtReg) == 4'h8 && glReg == 8'h10
    && $past(glReg) == 8'h10 && !inactiveFlag && !$past(inactiveFlag) && !$past(inactiveFlag, 2)
    |-> !pixelQualifier) else $error("gated qualifier not low in active video");
  a_rgb15_top: assert property (fmtReg == 4'h1 && $past(fmtReg) == 4'h1 && $past(pixStrobe)
    |-> !pixOut[15]) else $error("top line set in 15-bit colour");
  c_trs: cover property (trsStart);
  c_gated: cover property (glReg[4] && !inactiveFlag);
  c_refused: cover property (psel && penable && pslverr);
endmodule // vpo_pixel_port_props
`default_nettype wire

// ### tb/vpo_capture_model.sv
// Capture controller model: latches each qualified word off the pixel port
`timescale 1ns/10ps
`default_nettype none
module vpo_capture_model (
  input  wire logic        clk,            // Sample clock
  input  wire logic        reset,          // Async reset
  input  wire logic [15:0] pixOut,         // Pixel lines
  input  wire logic        pixelQualifier, // Qualifier from port
  input  wire logic        qualLow,        // Configured polarity, 1 active low
  output var  logic [15:0] capWord,        // Captured word
  output var  logic        capValid        // One pulse per captured word
);
  // Latch on any qualified edge; spacing is never assumed, as the rate converter slips
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capWord <= 16'h0000;
      capValid <= 1'b0;
    end else begin
      capValid <= pixelQualifier ^ qualLow;
      capWord <= pixOut;
    end
  end
endmodule // vpo_capture_model
`default_nettype wire

// ### tb/test_video_pixel_output_port.sv
// Testbench for the pixel output port: registers, 16-bit formats, qualifier modes, embedded sync
`timescale 1ns/10ps
`default_nettype none
`include "vpo_defines.vh"
module test_video_pixel_output_port;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, pixStrobe = 1'b0, ancActive = 1'b0, qualLow = 1'b0, watch = 1'b1;
  logic [7:0]  yIn = 8'h00, cbIn = 8'h00, crIn = 8'h00, rIn = 8'h00, gIn = 8'h00, bIn = 8'h00, ancByte = 8'h00;
  logic [15:0] pixOut, capWord;
  logic        inactiveFlag, hsyncOut, vsyncOut, pixelQualifier, ancillaryWindowFlag, fieldOut, capValid;
  logic [16:0] expQ[$];
  logic [16:0] e;
  int          fails = 0, n_tests = 0, hc = 0, ns = 0;
  always #12.5 clk = ~clk;
  vpo_pixel_port #(.CNT_W(10)) dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pixStrobe, .yIn, .cbIn, .crIn, .rIn, .gIn, .bIn, .ancActive, .ancByte, .pixOut, .inactiveFlag,
    .hsyncOut, .vsyncOut, .pixelQualifier, .ancillaryWindowFlag, .fieldOut);
  vpo_capture_model cap (.clk, .reset, .pixOut, .pixelQualifier, .qualLow, .capWord, .capValid);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, {2'b00, i, 2'b00}, d, rd, err);
  endtask
  function automatic logic [7:0] gm(input logic [7:0] x);
    logic [15:0] p;
    p = x * (8'hff - x);
    return x + p[15:9];
  endfunction
  // Random pixels at random spacing; each step leaves a note, masked near blanking edges
  task automatic run(input logic [3:0] fmt, input int n);
    logic [7:0]  v[6];
    logic [7:0]  c[3];
    logic [15:0] x;
    logic        act, blk, a, ap;
    int          g;
    ap = ancActive;
    wr(`VPO_IDX_FORMAT, {28'h0, fmt});
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      foreach (v[j]) v[j] = $urandom;
      foreach (c[j]) c[j] = fmt[2] ? gm(v[j + 3]) : v[j + 3];
      a = ($urandom % 8) == 0;
      act = hc >= 7 && hc <= 26;
      blk = (hc >= 30 || hc <= 2) && !a && !ap;
      case (fmt[1:0])
        // First active pixel follows hEnd 4, so Cb lands on odd counts
        2'h0: x = act ? {v[0], hc[0] ? v[1] : v[2]} : {`VPO_LUMA_BLK, `VPO_CHROMA_BLK};
        2'h1: x = act ? {1'b0, c[0][7:3], c[1][7:3], c[2][7:3]} : 16'h0000;
        default: x = act ? {c[0][7:3], c[1][7:2], c[2][7:3]} : 16'h0000;
      endcase
      pixStrobe <= 1'b1;
      {yIn, cbIn, crIn, rIn, gIn, bIn} <= {v[0], v[1], v[2], v[3], v[4], v[5]};
      ancActive <= a;
      ancByte <= v[0];
      expQ.push_back({act || blk, x});
      hc = (hc == 31) ? 0 : hc + 1;
      ns++;
      ap = a;
      g = $urandom % 3;
      if (g > 0) begin
        @(posedge clk);
        pixStrobe <= 1'b0;
        repeat (g - 1) @(posedge clk);
      end
    end
    @(posedge clk);
    pixStrobe <= 1'b0;
  endtask
  // Compare each captured word with the oldest note
  always @(posedge clk) begin
    if (watch && capValid === 1'b1) begin
      if (expQ.size() == 0) check("capture count", 32'h1, 32'h0);
      else begin
        e = expQ.pop_front();
        if (e[16]) check("pixOut", {16'h0, capWord}, {16'h0, e[15:0]});
      end
    end
  end
  initial begin
    logic [31:0] rd;
    logic        err;
    logic [7:0]  idx[8];
    logic [9:0]  rv[8];
    int          seed;
    idx = '{`VPO_IDX_GENLOCK, `VPO_IDX_FORMAT, `VPO_IDX_HTOTAL, `VPO_IDX_VTOTAL, `VPO_IDX_HSTART, `VPO_IDX_HEND,
            `VPO_IDX_VSTART, `VPO_IDX_VEND};
    rv = '{10'h000, 10'h000, `VPO_RST_HTOTAL, `VPO_RST_VTOTAL, `VPO_RST_HSTART, `VPO_RST_HEND, `VPO_RST_VSTART,
           `VPO_RST_VEND};
    seed = $urandom(82);
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Reset values, then an unaligned and an unmapped access
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, {2'b00, idx[i], 2'b00}, 32'h0, rd, err);
      check("reset value", rd, {22'h0, rv[i]});
    end
    apb(1'b0, 12'h011, 32'h0, rd, err);
    check("unaligned error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h3fc, 32'h0, rd, err);
    check("unmapped data", rd, 32'h0);
    // Short lines so blanking comes round often; every-pixel qualifier for capture
    wr(`VPO_IDX_HTOTAL, 32'd31);
    wr(`VPO_IDX_HSTART, 32'd28);
    wr(`VPO_IDX_HEND, 32'd4);
    wr(`VPO_IDX_VSTART, 32'h3ff);
    wr(`VPO_IDX_VEND, 32'h0);
    wr(`VPO_IDX_GENLOCK, 32'h20);
    run(4'h0, 300);
    run(4'h1, 200);
    run(4'h6, 200);
    run(4'h2, 100);
    repeat (4) @(posedge clk);
    check("notes left", 32'(expQ.size()), 32'h0);
    // Counters stand still between strobes, so status and syncs follow the step count
    apb(1'b0, {2'b00, `VPO_IDX_STATUS, 2'b00}, 32'h0, rd, err);
    check("status", rd, {8'h00, 1'b0, 1'(hc >= 29 || hc <= 4), 2'b00, 10'(ns / 32), 10'(hc)});
    check("syncs", {29'h0, hsyncOut, vsyncOut, fieldOut},
          {29'h0, 1'(hc < `VPO_HSYNC_LEN), 1'(ns / 32 < `VPO_VSYNC_LINES), 1'b0});
    // Latching qualifier needs active-low polarity
    watch = 1'b0;
    qualLow = 1'b1;
    wr(`VPO_IDX_GENLOCK, 32'h10);
    run(4'h8, 150);
    expQ.delete();
    // Embedded sync: one byte every clock, references checked at the port
    qualLow = 1'b0;
    ancActive <= 1'b0;
    wr(`VPO_IDX_GENLOCK, 32'h20);
    wr(`VPO_IDX_FORMAT, 32'h3);
    repeat (400) begin
      @(posedge clk);
      {yIn, cbIn, crIn} <= 24'($urandom);
    end
    test_done();
  end
  // Watchdog: about eight times the expected run
  initial begin
    #500000;
    fails++;
    test_done();
  end
endmodule // test_video_pixel_output_port
bind vpo_pixel_port vpo_pixel_port_props u_props (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .pixStrobe, .ancActive, .pixOut, .inactiveFlag, .pixelQualifier, .ancillaryWindowFlag);
`default_nettype wire
